// [rtl/amcr_regs.sv]
// mode and clock configuration registers with reset flag and data-ready pin driver
`timescale 1ns/1ps
module amcr_regs (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire amcr_pkg::amcr_req_s req, // register access from the command decoder
  input wire logic reset_cmd, // one-cycle pulse: reset command decoded
  input wire logic [1:0] chan_new_data, // per-channel new data available level
  output logic [15:0] rd_data_q, // read data
  output logic rd_valid_q, // read data valid pulse
  output logic reset_flag_q, // reset-occurred status indication
  output amcr_pkg::amcr_cfg_s cfg_q, // decoded configuration
  output logic [15:0] mode_q, // raw mode register
  output logic [15:0] clock_q, // raw clock register
  output logic data_ready_pin_out_q, // ready pin output level
  output logic data_ready_pin_oe_n_q // ready pin output enable, low drives
);
  import amcr_pkg::*;

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [3:0] div_ratio(input logic [1:0] code);
    case (code)
      2'h0: div_ratio = 4'h2;
      2'h1: div_ratio = 4'h4;
      2'h2: div_ratio = 4'h8;
      default: div_ratio = 4'hc;
    endcase
  endfunction

  function automatic logic [14:0] osr_of(input logic turbo, input logic [2:0] code);
    if (turbo) begin
      osr_of = OSR_TURBO;
    end else begin
      osr_of = OSR_BASE << code;
    end
  endfunction

  function automatic amcr_cfg_s decode(input logic [15:0] m, input logic [15:0] c);
    amcr_cfg_s r;
    r.reg_crc_en = m[MODE_REG_CRC_BIT];
    r.rx_crc_en = m[MODE_RX_CRC_BIT];
    r.crc_ansi = m[MODE_CRC_TYPE_BIT];
    r.word_size_select = m[MODE_WLEN_LSB +: 2];
    r.pad_zero = (m[MODE_WLEN_LSB +: 2] == WLEN_32_PAD);
    r.sign_extend = (m[MODE_WLEN_LSB +: 2] == WLEN_32_SEXT);
    r.timeout_en = m[MODE_TIMEOUT_BIT];
    r.chan1_enable = c[CLK_CH1_BIT];
    r.chan0_enable = c[CLK_CH0_BIT];
    r.clk_div_ratio = div_ratio(c[CLK_DIV_LSB +: 2]);
    r.turbo = c[CLK_TURBO_BIT];
    r.osr_value = osr_of(c[CLK_TURBO_BIT], c[CLK_OSR_LSB +: 3]);
    r.power_mode_select = c[CLK_PWR_LSB +: 2];
    decode = r;
  endfunction

  // reset image of the decoded outputs, fixed at elaboration
  localparam amcr_cfg_s CFG_RST = decode(MODE_RST, CLOCK_RST);

  // register file
  logic [15:0] mode_d;
  logic [15:0] clock_d;
  logic reset_flag_d;
  logic [15:0] rd_data_d;
  logic rd_valid_d;
  amcr_cfg_s cfg_d;
  logic wr_mode;
  logic wr_clock;

  assign wr_mode = req.wr && (req.addr == MODE_ADDR);
  assign wr_clock = req.wr && (req.addr == CLOCK_ADDR);

  always_comb begin
    mode_d = mode_q;
    clock_d = clock_q;
    reset_flag_d = reset_flag_q;
    rd_valid_d = req.rd;
    rd_data_d = 16'h0000;
    if (req.rd && (req.addr == MODE_ADDR)) begin
      rd_data_d = mode_q;
    end else if (req.rd && (req.addr == CLOCK_ADDR)) begin
      rd_data_d = clock_q;
    end
    if (wr_mode) begin
      mode_d = req.wdata;
      if (!req.wdata[MODE_RST_FLAG_BIT]) begin
        reset_flag_d = 1'b0;
      end
    end
    if (wr_clock) begin
      clock_d = req.wdata;
    end
    if (reset_cmd) begin
      mode_d = MODE_RST;
      clock_d = CLOCK_RST;
      reset_flag_d = 1'b1;
    end
    cfg_d = decode(mode_d, clock_d);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= MODE_RST;
      clock_q <= CLOCK_RST;
      reset_flag_q <= 1'b1;
      rd_data_q <= 16'h0000;
      rd_valid_q <= 1'b0;
      cfg_q <= CFG_RST;
    end else begin
      mode_q <= mode_d;
      clock_q <= clock_d;
      reset_flag_q <= reset_flag_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      cfg_q <= cfg_d;
    end
  end

  // data-ready pin
  logic [1:0] en_mask;
  logic [1:0] pend;
  logic [1:0] lead_mask_q;
  logic [1:0] lead_mask_d;
  logic active_q;
  logic active_d;
  logic [2:0] pulse_cnt_q;
  logic [2:0] pulse_cnt_d;
  logic asserted;
  logic pin_out_d;
  logic pin_oe_n_d;

  assign en_mask = {cfg_q.chan1_enable, cfg_q.chan0_enable};
  assign pend = chan_new_data & en_mask;

  always_comb begin
    lead_mask_d = lead_mask_q;
    if (pend == 2'h0) begin
      lead_mask_d = 2'h0;
    end else if (lead_mask_q == 2'h0) begin
      lead_mask_d = pend;
    end
    case (mode_q[MODE_SRC_LSB +: 2])
      SRC_LAGGING: active_d = (en_mask != 2'h0) && (pend == en_mask);
      SRC_OR: active_d = (pend != 2'h0);
      default: active_d = ((pend & lead_mask_d) != 2'h0);
    endcase
    pulse_cnt_d = pulse_cnt_q;
    if (active_d && !active_q) begin
      pulse_cnt_d = 3'(READY_PULSE_CYCLES);
    end else if (pulse_cnt_q != 3'h0) begin
      pulse_cnt_d = pulse_cnt_q - 3'h1;
    end
    if (mode_q[MODE_FMT_BIT]) begin
      asserted = (pulse_cnt_d != 3'h0);
    end else begin
      asserted = active_d;
    end
    pin_out_d = !asserted;
    pin_oe_n_d = !asserted && mode_q[MODE_HIZ_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lead_mask_q <= 2'h0;
      active_q <= 1'b0;
      pulse_cnt_q <= PULSE_CNT_RST;
      data_ready_pin_out_q <= 1'b1;
      data_ready_pin_oe_n_q <= 1'b0;
    end else begin
      lead_mask_q <= lead_mask_d;
      active_q <= active_d;
      pulse_cnt_q <= pulse_cnt_d;
      data_ready_pin_out_q <= pin_out_d;
      data_ready_pin_oe_n_q <= pin_oe_n_d;
    end
  end

  // checks
  a_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_cmd |=> reset_flag_q)
    else $error("reset flag not set by reset command");

  a_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_mode && !req.wdata[10] && !reset_cmd) |=> !reset_flag_q)
    else $error("reset flag not cleared by mode write");

  a_cmd_defaults: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_cmd |=> (clock_q == 16'h030e) && (mode_q == 16'h0510))
    else $error("reset command did not restore defaults");

  a_read_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req.rd && req.addr == 6'h03) |=> rd_valid_q && rd_data_q == $past(clock_q))
    else $error("clock register read mismatch");

  a_read_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req.rd && req.addr == 6'h02) |=> rd_valid_q && rd_data_q == $past(mode_q))
    else $error("mode register read mismatch");

  a_turbo_osr: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clock_q[5] |-> cfg_q.osr_value == 15'h0040)
    else $error("turbo did not force oversampling 64");

  a_osr_table: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !clock_q[5] |-> cfg_q.osr_value == (15'h0080 << clock_q[4:2]))
    else $error("oversampling ratio decode wrong");

  a_div_twelve: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clock_q[7:6] == 2'h3 |-> cfg_q.clk_div_ratio == 4'hc)
    else $error("divide by twelve decode wrong");

  a_crc_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_q.crc_ansi == mode_q[11] && cfg_q.reg_crc_en == mode_q[13]
      && cfg_q.rx_crc_en == mode_q[12])
    else $error("crc control fields do not follow mode register");

  sequence s_pulse_start;
    active_d && !active_q && mode_q[0];
  endsequence

  // pulse format kept through the four launching edges
  sequence s_fmt_held;
    mode_q[0] [*4];
  endsequence

  // pin low on the four edges after the start: now and the three before
  a_pulse_width: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_pulse_start ##0 s_fmt_held |=> !data_ready_pin_out_q && !data_ready_pin_oe_n_q
      && !$past(data_ready_pin_out_q, 1) && !$past(data_ready_pin_out_q, 2)
      && !$past(data_ready_pin_out_q, 3))
    else $error("ready pulse width wrong");

  a_level_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!mode_q[0] && active_d) |=> !data_ready_pin_out_q && !data_ready_pin_oe_n_q)
    else $error("ready level not held low");

  a_idle_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!mode_q[0] && !active_d) |=> data_ready_pin_oe_n_q == $past(mode_q[1])
      && data_ready_pin_out_q)
    else $error("ready idle state wrong");

  a_flag_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_mode && req.wdata[MODE_RST_FLAG_BIT] && !reset_cmd)
      |=> reset_flag_q == $past(reset_flag_q))
    else $error("reset flag changed by writing one");

  a_set_wins: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (reset_cmd && wr_mode) |=> reset_flag_q && (mode_q == MODE_RST))
    else $error("reset command lost against mode write");

  a_write_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_mode && !reset_cmd) |=> mode_q == $past(req.wdata))
    else $error("mode write not stored as written");

  a_write_clock: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_clock && !reset_cmd) |=> clock_q == $past(req.wdata))
    else $error("clock write not stored as written");

  a_word_size: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_q.word_size_select == mode_q[9:8] && cfg_q.pad_zero == (mode_q[9:8] == 2'h2)
      && cfg_q.sign_extend == (mode_q[9:8] == 2'h3))
    else $error("word size fields do not follow mode register");

  a_chan_timeout: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_q.timeout_en == mode_q[4] && cfg_q.chan1_enable == clock_q[9]
      && cfg_q.chan0_enable == clock_q[8])
    else $error("timeout or channel enables do not follow registers");

  a_div_small: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clock_q[7:6] != 2'h3 |-> cfg_q.clk_div_ratio == (4'h2 << clock_q[7:6]))
    else $error("clock divide decode wrong");

  a_power_field: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cfg_q.power_mode_select == clock_q[1:0] && cfg_q.turbo == clock_q[5])
    else $error("power or turbo field does not follow clock register");

  a_src_or: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode_q[3:2] == 2'h1 && !mode_q[0] && (chan_new_data & {clock_q[9], clock_q[8]}) != 2'h0)
      |=> !data_ready_pin_out_q)
    else $error("ready pin not low for any enabled channel");

endmodule

// [include/amcr_pkg.sv]
// package of offsets, reset values, field positions and carriers for the config registers
package amcr_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 16;

  localparam logic [ADDR_W-1:0] MODE_ADDR = 6'h02;
  localparam logic [ADDR_W-1:0] CLOCK_ADDR = 6'h03;

  localparam logic [DATA_W-1:0] MODE_RST = 16'h0510;
  localparam logic [DATA_W-1:0] CLOCK_RST = 16'h030e;

  // mode field positions
  localparam int MODE_REG_CRC_BIT = 13;
  localparam int MODE_RX_CRC_BIT = 12;
  localparam int MODE_CRC_TYPE_BIT = 11;
  localparam int MODE_RST_FLAG_BIT = 10;
  localparam int MODE_WLEN_LSB = 8;
  localparam int MODE_TIMEOUT_BIT = 4;
  localparam int MODE_SRC_LSB = 2;
  localparam int MODE_HIZ_BIT = 1;
  localparam int MODE_FMT_BIT = 0;

  // clock field positions
  localparam int CLK_CH1_BIT = 9;
  localparam int CLK_CH0_BIT = 8;
  localparam int CLK_DIV_LSB = 6;
  localparam int CLK_TURBO_BIT = 5;
  localparam int CLK_OSR_LSB = 2;
  localparam int CLK_PWR_LSB = 0;

  // word size codes
  localparam logic [1:0] WLEN_16 = 2'h0;
  localparam logic [1:0] WLEN_24 = 2'h1;
  localparam logic [1:0] WLEN_32_PAD = 2'h2;
  localparam logic [1:0] WLEN_32_SEXT = 2'h3;

  // ready source codes
  localparam logic [1:0] SRC_LAGGING = 2'h0;
  localparam logic [1:0] SRC_OR = 2'h1;

  // power codes
  localparam logic [1:0] PWR_LOW = 2'h1;
  localparam logic [1:0] PWR_HIGH_RES = 2'h2;

  localparam logic [14:0] OSR_TURBO = 15'h0040;
  localparam logic [14:0] OSR_BASE = 15'h0080;

  // ready pulse width
  localparam int SYS_CLK_PERIOD_NS = 40;
  localparam int READY_PULSE_NS = 160;
  localparam int READY_PULSE_CYCLES =
    (READY_PULSE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam logic [2:0] PULSE_CNT_RST = 3'h0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amcr_req_s;

  typedef struct packed {
    logic reg_crc_en;
    logic rx_crc_en;
    logic crc_ansi;
    logic [1:0] word_size_select;
    logic pad_zero;
    logic sign_extend;
    logic timeout_en;
    logic chan1_enable;
    logic chan0_enable;
    logic [3:0] clk_div_ratio;
    logic turbo;
    logic [14:0] osr_value;
    logic [1:0] power_mode_select;
  } amcr_cfg_s;

endpackage

// [verification/amcr_host.sv]
// host model that issues register accesses on the request port
`timescale 1ns/1ps
module amcr_host (
  input wire logic sys_clk, // system clock
  output amcr_pkg::amcr_req_s req, // register request
  input wire logic [15:0] rd_data_q, // read data
  input wire logic rd_valid_q // read data valid
);
  import amcr_pkg::*;
  initial req = '0;
  // callers pass zero reserved clock bits and legal power codes only
  task automatic write(input logic [5:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    req <= '0;
    #1;
  endtask
  task automatic read(input logic [5:0] a, output logic [15:0] d, output logic v);
    @(posedge sys_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    req <= '0;
    #1;
    d = rd_data_q;
    v = rd_valid_q;
  endtask
endmodule

// [verification/testbench.sv]
// self-checking bench for the mode and clock configuration registers
`timescale 1ns/1ps
module testbench;
  import amcr_pkg::*;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reset_cmd = 1'b0;
  logic [1:0] chan_new_data = 2'h0;
  amcr_req_s req;
  amcr_cfg_s cfg_q;
  logic [15:0] rd_data_q, mode_q, clock_q, rd, m;
  logic rd_valid_q, reset_flag_q, pin_q, oe_n_q, v;
  int divs[4] = '{2, 4, 8, 12};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #20 sys_clk = ~sys_clk;
  amcr_host host (.sys_clk(sys_clk), .req(req), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q));
  amcr_regs uut (.sys_clk(sys_clk), .arst_n(arst_n), .req(req), .reset_cmd(reset_cmd),
    .chan_new_data(chan_new_data), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .reset_flag_q(reset_flag_q), .cfg_q(cfg_q), .mode_q(mode_q), .clock_q(clock_q),
    .data_ready_pin_out_q(pin_q), .data_ready_pin_oe_n_q(oe_n_q));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    host.read(a, rd, v);
    chk("rd_valid", 16'h0001, 16'(v));
    chk("rd_data", e, rd);
  endtask
  task automatic drv(input logic [1:0] c);
    @(posedge sys_clk);
    chan_new_data <= c;
    tick(1);
  endtask
  task automatic cmd_pulse();
    @(posedge sys_clk);
    reset_cmd <= 1'b1;
    @(posedge sys_clk);
    reset_cmd <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    tick(3);
    chk("flag", 16'h0001, 16'(reset_flag_q));
    chk("mode_cfg", 16'h0003, 16'({cfg_q.reg_crc_en, cfg_q.rx_crc_en, cfg_q.crc_ansi,
      cfg_q.word_size_select, cfg_q.timeout_en}));
    chk("osr", 16'h0400, 16'(cfg_q.osr_value));
    chk("div", 16'h0002, 16'(cfg_q.clk_div_ratio));
    chk("turbo", 16'h0000, 16'(cfg_q.turbo));
    chk("chan_en", 16'h0003, 16'({cfg_q.chan1_enable, cfg_q.chan0_enable}));
    chk("pwr", 16'(PWR_HIGH_RES), 16'(cfg_q.power_mode_select));
    chk("pin_idle", 16'h0002, 16'({pin_q, oe_n_q}));
    rdchk(MODE_ADDR, MODE_RST);
    rdchk(CLOCK_ADDR, CLOCK_RST);
    rdchk(6'h05, 16'h0000);
    host.write(MODE_ADDR, 16'h0110);
    chk("flag_clr", 16'h0000, 16'(reset_flag_q));
    host.write(MODE_ADDR, 16'h0510);
    chk("flag_hold", 16'h0000, 16'(reset_flag_q));
    for (int w = 0; w < 4; w++) begin
      m = {2'h0, 3'h7, 1'b0, 2'(w), 8'h10};
      host.write(MODE_ADDR, m);
      chk("wsize", {8'h0, 3'h7, 2'(w), 1'(w == 2), 1'(w == 3), 1'b1},
        16'({cfg_q.reg_crc_en, cfg_q.rx_crc_en, cfg_q.crc_ansi, cfg_q.word_size_select,
        cfg_q.pad_zero, cfg_q.sign_extend, cfg_q.timeout_en}));
      rdchk(MODE_ADDR, m);
    end
    for (int k = 0; k < 8; k++) begin
      m = {6'h0, 1'(k), ~1'(k), 2'(k), 1'b0, 3'(k), k[0] ? PWR_LOW : PWR_HIGH_RES};
      host.write(CLOCK_ADDR, m);
      chk("chan_en", 16'({1'(k), ~1'(k)}),
        16'({cfg_q.chan1_enable, cfg_q.chan0_enable}));
      chk("div", 16'(divs[k % 4]), 16'(cfg_q.clk_div_ratio));
      chk("osr", 16'(128 << k), 16'(cfg_q.osr_value));
      chk("pwr", 16'(m[1:0]), 16'(cfg_q.power_mode_select));
      rdchk(CLOCK_ADDR, m);
    end
    host.write(CLOCK_ADDR, 16'h033e);
    chk("osr_turbo", 16'h0040, 16'(cfg_q.osr_value));
    chk("turbo", 16'h0001, 16'(cfg_q.turbo));
    host.write(CLOCK_ADDR, CLOCK_RST);
    host.write(MODE_ADDR, 16'h0014);
    drv(2'h1);
    chk("pin_or", 16'h0000, 16'({pin_q, oe_n_q}));
    drv(2'h0);
    chk("pin_idle", 16'h0002, 16'({pin_q, oe_n_q}));
    host.write(MODE_ADDR, 16'h0010);
    drv(2'h1);
    chk("pin_lag1", 16'h0002, 16'({pin_q, oe_n_q}));
    drv(2'h3);
    chk("pin_lag2", 16'h0000, 16'({pin_q, oe_n_q}));
    drv(2'h0);
    host.write(MODE_ADDR, 16'h0018);
    drv(2'h1);
    chk("pin_lead1", 16'h0000, 16'({pin_q, oe_n_q}));
    drv(2'h3);
    chk("pin_lead2", 16'h0000, 16'({pin_q, oe_n_q}));
    drv(2'h2);
    chk("pin_lead3", 16'h0002, 16'({pin_q, oe_n_q}));
    drv(2'h0);
    host.write(MODE_ADDR, 16'h0012);
    tick(1);
    chk("pin_float", 16'h0003, 16'({pin_q, oe_n_q}));
    host.write(MODE_ADDR, 16'h0015);
    drv(2'h1);
    for (int i = 1; i < READY_PULSE_CYCLES; i++) begin
      chk("pulse", 16'h0000, 16'({pin_q, oe_n_q}));
      tick(1);
    end
    chk("pulse_end", 16'h0000, 16'({pin_q, oe_n_q}));
    tick(1);
    chk("pulse_idle", 16'h0002, 16'({pin_q, oe_n_q}));
    drv(2'h0);
    host.write(CLOCK_ADDR, 16'h0321);
    cmd_pulse();
    #1;
    chk("flag_cmd", 16'h0001, 16'(reset_flag_q));
    chk("mode_cmd", MODE_RST, mode_q);
    chk("clock_cmd", CLOCK_RST, clock_q);
    host.write(MODE_ADDR, 16'h0110);
    chk("flag_clr2", 16'h0000, 16'(reset_flag_q));
    fork
      host.write(MODE_ADDR, 16'h0110);
      cmd_pulse();
    join
    chk("flag_win", 16'h0001, 16'(reset_flag_q));
    chk("mode_win", MODE_RST, mode_q);
    finish_test();
  end
endmodule
